// ---- rtl/tcs_pkg.sv ----
// constants shared by the timer channel status and interrupt block
package tcs_pkg;
   // register byte offsets
   localparam logic [7:0] TCS_OFF_CTRL = 8'h00;
   localparam logic [7:0] TCS_OFF_MODE = 8'h04;
   localparam logic [7:0] TCS_OFF_COUNT = 8'h10;
   localparam logic [7:0] TCS_OFF_VAL_A = 8'h14;
   localparam logic [7:0] TCS_OFF_VAL_B = 8'h18;
   localparam logic [7:0] TCS_OFF_VAL_C = 8'h1c;
   localparam logic [7:0] TCS_OFF_STATUS = 8'h20;
   localparam logic [7:0] TCS_OFF_IRQ_SET = 8'h24;
   localparam logic [7:0] TCS_OFF_IRQ_CLR = 8'h28;
   localparam logic [7:0] TCS_OFF_IRQ_VIEW = 8'h2c;
   // field positions
   localparam int TCS_CTRL_SOFT_TRIG = 2;
   localparam int TCS_MODE_WAVE = 15;
   localparam int TCS_MODE_ACT_B_LO = 30;
   localparam int TCS_ST_CLOCK_RUNNING = 16;
   localparam int TCS_ST_MIRROR_A = 17;
   localparam int TCS_ST_MIRROR_B = 18;
   // sticky flag indices
   localparam int TCS_F_OVF = 0;
   localparam int TCS_F_OVR = 1;
   localparam int TCS_F_MA = 2;
   localparam int TCS_F_MB = 3;
   localparam int TCS_F_MC = 4;
   localparam int TCS_F_LA = 5;
   localparam int TCS_F_LB = 6;
   localparam int TCS_F_ET = 7;
   // flags that only exist in one mode
   localparam logic [7:0] TCS_WAVE_ONLY = 8'h0c;
   localparam logic [7:0] TCS_CAPT_ONLY = 8'h62;
   // reset values
   localparam logic [15:0] TCS_VAL_RST = 16'h0000;
   localparam logic [7:0] TCS_FLAG_RST = 8'h00;
   localparam logic [31:0] TCS_MODE_RST = 32'h0000_0000;
   // soft trigger action codes for line b
   localparam logic [1:0] TCS_ACT_NONE = 2'h0;
   localparam logic [1:0] TCS_ACT_HIGH = 2'h1;
   localparam logic [1:0] TCS_ACT_LOW = 2'h2;
   localparam logic [1:0] TCS_ACT_TOGGLE = 2'h3;
endpackage

// ---- rtl/tcs_channel.sv ----
// timer channel register side: values, sticky status, interrupt mask, wishbone slave
// Operation
// - line b soft trigger: none, high, low, invert
// - count readout shows live 16-bit counter
// - values a and b writable only in waveform
// - value c read/write in both modes
// - overflow flag sticky until status read
// - capture reload without read sets overrun
// - a/b match flags only in waveform
// - c match flag in either mode
// - a/b load flags only in capture
// - external trigger flag in either mode
// - clock running bit is live level
// - mirror bits: pin or driven level
// - enable register sets mask on ones
// - disable register clears mask on ones
// - mask view shows enabled sources
// - wave bit: 0 capture, 1 waveform
`timescale 1ns/1ps
module tcs_channel
#(
   parameter int CW = 16 // counter width
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // counting engine, same clock
   input wire logic [CW-1:0] counter_value_i,
   input wire logic count_tick_i,
   input wire logic overflow_evt_i,
   input wire logic ext_trigger_evt_i,
   input wire logic load_a_evt_i,
   input wire logic load_b_evt_i,
   input wire logic clock_running_i,
   input wire logic drive_a_i,
   // io line a
   input wire logic io_line_a_i,
   output logic io_line_a_o,
   output logic io_line_a_oe_o,
   // io line b
   input wire logic io_line_b_i,
   output logic io_line_b_o,
   output logic io_line_b_oe_o,
   // mode out to the engine
   output logic wave_mode_o,
   output logic soft_trigger_o,
   // interrupt
   output logic irq_o
);
   import tcs_pkg::*;

   // byte lane expansion of wishbone select
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // masked merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // registers
   logic ack_reg; // wishbone acknowledge
   logic [31:0] rdata_reg; // read data held for the ack cycle
   logic [31:0] mode_reg; // wave bit and line b action
   logic [CW-1:0] val_a_reg; // value a
   logic [CW-1:0] val_b_reg; // value b
   logic [CW-1:0] val_c_reg; // value c
   logic [7:0] flags_reg; // sticky status flags
   logic [7:0] mask_reg; // interrupt enables
   logic unread_a_reg; // value a loaded, not yet read
   logic unread_b_reg; // value b loaded, not yet read
   logic line_b_reg; // driven level of line b
   logic line_a_reg; // driven level of line a, one clock behind the engine
   logic soft_trig_reg; // one-cycle trigger pulse
   logic [1:0] sync_a_reg; // line a synchroniser
   logic [1:0] sync_b_reg; // line b synchroniser

   // next values
   logic [7:0] flags_next;
   logic [7:0] mask_next;
   logic [CW-1:0] val_a_next;
   logic [CW-1:0] val_b_next;
   logic [CW-1:0] val_c_next;
   logic line_b_next;

   // bus decode
   wire req = wb_cyc_i & wb_stb_i & ~ack_reg; // new access, taken once
   wire wr = req & wb_we_i;
   wire rd = req & ~wb_we_i;
   wire [31:0] wmask = lane_mask(wb_sel_i);
   wire [31:0] wbits = wb_dat_i & wmask; // only enabled lanes count
   wire hit_ctrl = wb_adr_i == TCS_OFF_CTRL;
   wire hit_mode = wb_adr_i == TCS_OFF_MODE;
   wire hit_count = wb_adr_i == TCS_OFF_COUNT;
   wire hit_a = wb_adr_i == TCS_OFF_VAL_A;
   wire hit_b = wb_adr_i == TCS_OFF_VAL_B;
   wire hit_c = wb_adr_i == TCS_OFF_VAL_C;
   wire hit_st = wb_adr_i == TCS_OFF_STATUS;
   wire hit_set = wb_adr_i == TCS_OFF_IRQ_SET;
   wire hit_clr = wb_adr_i == TCS_OFF_IRQ_CLR;
   wire hit_view = wb_adr_i == TCS_OFF_IRQ_VIEW;

   // mode decode
   wire wave = mode_reg[TCS_MODE_WAVE];
   wire [1:0] act_b = mode_reg[TCS_MODE_ACT_B_LO +: 2];
   wire soft_trig = wr & hit_ctrl & wbits[TCS_CTRL_SOFT_TRIG];

   // lane merges of a bus write; values widened so the merge sees 32 bits
   wire [31:0] mrg_a = merge(32'(val_a_reg), wb_dat_i, wmask);
   wire [31:0] mrg_b = merge(32'(val_b_reg), wb_dat_i, wmask);
   wire [31:0] mrg_c = merge(32'(val_c_reg), wb_dat_i, wmask);

   // synchronised pin levels
   wire pin_a = sync_a_reg[1];
   wire pin_b = sync_b_reg[1];

   // capture loads only count in capture mode
   wire cap_a = load_a_evt_i & ~wave;
   wire cap_b = load_b_evt_i & ~wave;

   // compare matches on every counter update
   wire m_a = count_tick_i & (counter_value_i == val_a_reg);
   wire m_b = count_tick_i & (counter_value_i == val_b_reg);
   wire m_c = count_tick_i & (counter_value_i == val_c_reg);

   // overrun: a second load before the register was read
   wire ovr = (cap_a & unread_a_reg) | (cap_b & unread_b_reg);

   // events that set sticky flags this cycle
   logic [7:0] set_vec;
   assign set_vec[TCS_F_OVF] = overflow_evt_i;
   assign set_vec[TCS_F_OVR] = ovr;
   assign set_vec[TCS_F_MA] = m_a & wave;
   assign set_vec[TCS_F_MB] = m_b & wave;
   assign set_vec[TCS_F_MC] = m_c;
   assign set_vec[TCS_F_LA] = cap_a;
   assign set_vec[TCS_F_LB] = cap_b;
   assign set_vec[TCS_F_ET] = ext_trigger_evt_i;

   // flags visible in the present mode; others read zero
   wire [7:0] mode_gate = wave ? ~TCS_CAPT_ONLY : ~TCS_WAVE_ONLY;
   wire [7:0] flags_vis = flags_reg & mode_gate;

   // mirror levels
   wire mir_a = wave ? io_line_a_o : pin_a;
   wire mir_b = wave ? line_b_reg : pin_b;

   // status word
   logic [31:0] status_word;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[7:0] = flags_vis;
      status_word[TCS_ST_CLOCK_RUNNING] = clock_running_i;
      status_word[TCS_ST_MIRROR_A] = mir_a;
      status_word[TCS_ST_MIRROR_B] = mir_b;
   end

   // read mux; write-only and unmapped offsets read zero
   logic [31:0] rmux;
   always_comb
   begin
      rmux = 32'h0000_0000;
      if (hit_mode)
      begin
         rmux = mode_reg;
      end
      else if (hit_count)
      begin
         rmux[CW-1:0] = counter_value_i;
      end
      else if (hit_a)
      begin
         rmux[CW-1:0] = val_a_reg;
      end
      else if (hit_b)
      begin
         rmux[CW-1:0] = val_b_reg;
      end
      else if (hit_c)
      begin
         rmux[CW-1:0] = val_c_reg;
      end
      else if (hit_st)
      begin
         rmux = status_word;
      end
      else if (hit_view)
      begin
         rmux[7:0] = mask_reg;
      end
   end

   // sticky flags: read clears what it returned, a new event still sets
   always_comb
   begin
      flags_next = flags_reg;
      if (rd & hit_st)
      begin
         // a flag hidden by the mode was not returned, so it stays set
         flags_next = flags_reg & ~flags_vis;
      end
      flags_next = flags_next | set_vec;
   end

   // interrupt mask: set then clear; both in one write cannot happen
   always_comb
   begin
      mask_next = mask_reg;
      if (wr & hit_set)
      begin
         mask_next = mask_reg | wbits[7:0];
      end
      else if (wr & hit_clr)
      begin
         mask_next = mask_reg & ~wbits[7:0];
      end
   end

   // values a and b: capture loads in capture mode, software in waveform
   always_comb
   begin
      val_a_next = val_a_reg;
      val_b_next = val_b_reg;
      if (cap_a)
      begin
         val_a_next = counter_value_i;
      end
      else if (wr & hit_a & wave)
      begin
         val_a_next = mrg_a[CW-1:0];
      end
      if (cap_b)
      begin
         val_b_next = counter_value_i;
      end
      else if (wr & hit_b & wave)
      begin
         val_b_next = mrg_b[CW-1:0];
      end
   end

   // value c always writable
   always_comb
   begin
      val_c_next = val_c_reg;
      if (wr & hit_c)
      begin
         val_c_next = mrg_c[CW-1:0];
      end
   end

   // line b soft trigger action
   always_comb
   begin
      line_b_next = line_b_reg;
      if (soft_trig)
      begin
         case (act_b)
            TCS_ACT_NONE: line_b_next = line_b_reg;
            TCS_ACT_HIGH: line_b_next = 1'b1;
            TCS_ACT_LOW: line_b_next = 1'b0;
            TCS_ACT_TOGGLE: line_b_next = ~line_b_reg;
            default: line_b_next = line_b_reg;
         endcase
      end
   end

   // wishbone handshake and read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= req; // one wait state, drops after one cycle
         rdata_reg <= rd ? rmux : 32'h0000_0000;
      end
   end

   // mode register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_reg <= TCS_MODE_RST;
      end
      else if (wr & hit_mode)
      begin
         mode_reg <= merge(mode_reg, wb_dat_i, wmask);
      end
   end

   // value registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         val_a_reg <= TCS_VAL_RST;
         val_b_reg <= TCS_VAL_RST;
         val_c_reg <= TCS_VAL_RST;
      end
      else
      begin
         val_a_reg <= val_a_next;
         val_b_reg <= val_b_next;
         val_c_reg <= val_c_next;
      end
   end

   // unread tracking; a load in the read cycle keeps it set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         unread_a_reg <= 1'b0;
         unread_b_reg <= 1'b0;
      end
      else
      begin
         unread_a_reg <= cap_a | (unread_a_reg & ~(rd & hit_a));
         unread_b_reg <= cap_b | (unread_b_reg & ~(rd & hit_b));
      end
   end

   // flags and mask
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flags_reg <= TCS_FLAG_RST;
         mask_reg <= TCS_FLAG_RST;
      end
      else
      begin
         flags_reg <= flags_next;
         mask_reg <= mask_next;
      end
   end

   // line drives and trigger pulse; line a is registered for a clean data output
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line_b_reg <= 1'b0;
         line_a_reg <= 1'b0;
         soft_trig_reg <= 1'b0;
      end
      else
      begin
         line_b_reg <= line_b_next;
         line_a_reg <= drive_a_i;
         soft_trig_reg <= soft_trig;
      end
   end

   // pin synchronisers; only the second stage is read, the first may be metastable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_a_reg <= 2'h0;
         sync_b_reg <= 2'h0;
      end
      else
      begin
         sync_a_reg <= {sync_a_reg[0], io_line_a_i};
         sync_b_reg <= {sync_b_reg[0], io_line_b_i};
      end
   end

   // outputs
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign io_line_a_o = line_a_reg;
   assign io_line_a_oe_o = wave; // lines are inputs in capture mode
   assign io_line_b_o = line_b_reg;
   assign io_line_b_oe_o = wave;
   assign wave_mode_o = wave;
   assign soft_trigger_o = soft_trig_reg;
   assign irq_o = |(flags_vis & mask_reg);
endmodule

// ---- tb/tcs_channel_sva.sv ----
// concurrent checks on the timer channel register side ports
`timescale 1ns/1ps
module tcs_channel_sva
   import tcs_pkg::*;
#(
   parameter int CW = 16 // counter width
)(
   // clock, reset and bus
   input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   // engine side and channel outputs
   input wire logic [CW-1:0] counter_value_i,
   input wire logic clock_running_i, drive_a_i, io_line_a_o, io_line_a_oe_o,
   input wire logic wave_mode_o, soft_trigger_o, irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken at this edge; a held stb after ack is not a new request
   wire tk = wb_cyc_i & wb_stb_i & !wb_ack_o;
   wire rd = tk & !wb_we_i;
   wire wr = tk & wb_we_i;
   ack_late_a: assert property (tk |=> wb_ack_o) else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
   count_read_a: assert property (rd && wb_adr_i == TCS_OFF_COUNT |=>
      wb_dat_o == 32'($past(counter_value_i))) else $error("count readout wrong");
   clock_live_a: assert property (rd && wb_adr_i == TCS_OFF_STATUS |=>
      wb_dat_o[TCS_ST_CLOCK_RUNNING] == $past(clock_running_i)) else $error("clock bit wrong");
   irq_clear_a: assert property (wr && wb_adr_i == TCS_OFF_IRQ_CLR && wb_sel_i[0] &&
      wb_dat_i[7:0] == 8'hff |=> !irq_o) else $error("irq after full disable");
   soft_trig_a: assert property (wr && wb_adr_i == TCS_OFF_CTRL && wb_sel_i[0] &&
      wb_dat_i[TCS_CTRL_SOFT_TRIG] |=> soft_trigger_o ##1 !soft_trigger_o) else $error("soft trigger pulse wrong");
   oe_mode_a: assert property (io_line_a_oe_o == wave_mode_o) else $error("enable not mode");
   line_drive_a: assert property (!$past(rst_i) |-> io_line_a_o == $past(drive_a_i))
      else $error("line a level wrong");
   cover property (rd && wb_adr_i == TCS_OFF_STATUS);
   cover property (soft_trigger_o);
   cover property (irq_o);
endmodule
bind tcs_channel tcs_channel_sva #(.CW(CW)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .counter_value_i(counter_value_i), .clock_running_i(clock_running_i),
   .drive_a_i(drive_a_i), .io_line_a_o(io_line_a_o), .io_line_a_oe_o(io_line_a_oe_o),
   .wave_mode_o(wave_mode_o), .soft_trigger_o(soft_trigger_o), .irq_o(irq_o));

// ---- tb/tb_top.sv ----
// self-checking bench for the timer channel register side
`timescale 1ns/1ps
module tb_top;
   import tcs_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0, run = 1, drv_a = 1, pin_a = 0, pin_b = 0;
   logic [7:0] adr = 8'h0;
   logic [3:0] ev = 4'h0;
   logic [3:0] sel = 4'hf;
   logic [15:0] cnt = 16'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q;
   wire logic [31:0] rdat;
   wire logic ack, irq, la_o, la_oe, lb_o, lb_oe, wave, strig;
   int bad_count, n_checks, flags, a, b, c, bl, t, sd;
   int acts[5] = '{1, 3, 2, 3, 0};
   tcs_channel #(.CW(16)) u_tcs_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .counter_value_i(cnt), .count_tick_i(tick), .overflow_evt_i(ev[0]), .ext_trigger_evt_i(ev[1]),
      .load_a_evt_i(ev[2]), .load_b_evt_i(ev[3]), .clock_running_i(run), .drive_a_i(drv_a),
      .io_line_a_i(pin_a), .io_line_a_o(la_o), .io_line_a_oe_o(la_oe), .io_line_b_i(pin_b),
      .io_line_b_o(lb_o), .io_line_b_oe_o(lb_oe), .wave_mode_o(wave), .soft_trigger_o(strig), .irq_o(irq));
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic complete_run;
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one classic cycle, released only after ack is seen; a hang is ended by the watchdog
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      wb(1'b0, ad, 32'h0);
      chk(q, e);
   endtask
   // status read: hidden flags of the other mode stay, visible ones clear
   task automatic rds(input int wv, input logic ma, input logic mb);
      logic [7:0] vis;
      vis = 8'(flags) & (wv != 0 ? ~TCS_CAPT_ONLY : ~TCS_WAVE_ONLY);
      rd(TCS_OFF_STATUS, {13'h0, mb, ma, run, 8'h0, vis});
      flags &= ~int'(vis);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_i);
      ev <= 4'h1 << k;
      @(posedge clk_i);
      ev <= 4'h0;
   endtask
   task automatic tk(input logic [15:0] v);
      @(posedge clk_i);
      cnt <= v;
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
   endtask
   initial
   begin
      #20us;
      bad_count++;
      complete_run;
   end
   initial
   begin
      sd = $urandom(32'he7955438);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(TCS_OFF_IRQ_VIEW, 32'h0);
      rd(TCS_OFF_IRQ_SET, 32'h0);
      rds(0, 1'b0, 1'b0);
      // bit 15 clear keeps c apart from the loaded values
      c = $urandom & 32'h7fff;
      wb(1'b1, TCS_OFF_VAL_C, 32'hffff0000 | c);
      rd(TCS_OFF_VAL_C, c);
      // only byte lane 0 lands; bit 15 of c stays clear
      t = $urandom;
      sel <= 4'h1;
      wb(1'b1, TCS_OFF_VAL_C, t);
      sel <= 4'hf;
      c = (c & 32'hff00) | (t & 32'hff);
      rd(TCS_OFF_VAL_C, c);
      wb(1'b1, TCS_OFF_VAL_A, $urandom);
      rd(TCS_OFF_VAL_A, 32'h0);
      t = 32'h8000 | ($urandom & 32'hffff);
      cnt <= 16'(t);
      rd(TCS_OFF_COUNT, t);
      pulse(2);
      t = 32'h8000 | ($urandom & 32'hffff);
      cnt <= 16'(t);
      pulse(2);
      rd(TCS_OFF_VAL_A, t);
      pulse(3);
      pulse(1);
      pulse(0);
      tk(16'(c));
      flags = 32'hf3;
      wb(1'b1, TCS_OFF_IRQ_SET, 32'hff);
      rd(TCS_OFF_IRQ_VIEW, 32'hff);
      chk({31'h0, irq}, 32'h1);
      rds(0, 1'b0, 1'b0);
      rds(0, 1'b0, 1'b0);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, TCS_OFF_IRQ_CLR, 32'hff);
      rd(TCS_OFF_IRQ_VIEW, 32'h0);
      run <= 1'b0;
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      repeat (3) @(posedge clk_i);
      rds(0, 1'b1, 1'b1);
      run <= 1'b1;
      wb(1'b1, TCS_OFF_MODE, 32'h8000);
      chk({28'h0, la_o, la_oe, lb_oe, wave}, 32'hf);
      drv_a <= 1'b0;
      a = c ^ 32'h0100;
      b = c ^ 32'h0200;
      wb(1'b1, TCS_OFF_VAL_A, a);
      wb(1'b1, TCS_OFF_VAL_B, b);
      rd(TCS_OFF_VAL_A, a);
      rd(TCS_OFF_VAL_B, b);
      tk(16'(a));
      tk(16'(b));
      flags = 32'h0c;
      wb(1'b1, TCS_OFF_IRQ_SET, 32'h0c);
      chk({31'h0, irq}, 32'h1);
      foreach (acts[i])
      begin
         wb(1'b1, TCS_OFF_MODE, (acts[i] << 30) | 32'h8000);
         wb(1'b1, TCS_OFF_CTRL, 32'h4);
         chk({31'h0, strig}, 32'h1);
         bl = acts[i] == 1 ? 1 : acts[i] == 2 ? 0 : acts[i] == 3 ? 1 - bl : bl;
         repeat (2) @(posedge clk_i);
         chk({31'h0, lb_o}, 32'(bl));
      end
      pulse(2);
      rds(1, 1'b0, 1'(bl));
      rd(8'h3c, 32'h0);
      complete_run;
   end
endmodule
